//--- design/psq_defines.svh
`ifndef PSQ_DEFINES_SVH
`define PSQ_DEFINES_SVH
// register byte offsets on the bus
`define PSQ_OFF_ROM_ADDR 8'h00
`define PSQ_OFF_ROM_DATA 8'h04
`define PSQ_OFF_STATUS 8'h08
`define PSQ_OFF_CTRL 8'h0C
// reset values
`define PSQ_SP_RST 2'h3
`define PSQ_HOLD_RST 1'h1
`define PSQ_PC_RST 11'h000
// control field position
`define PSQ_CTRL_HOLD_BIT 0
// fixed page for the single-word call
`define PSQ_PAGE2 4'h2
// machine cycles of the multi-cycle instructions
`define PSQ_TBL_CYC 2'h3
`define PSQ_RET_CYC 2'h2
`endif

//--- design/psq_pkg.sv
package psq_pkg;
   typedef enum logic [4:0] {
      PSQ_OP_NEXT, PSQ_OP_BRANCH, PSQ_OP_CALL, PSQ_OP_PAGE2_CALL, PSQ_OP_BRANCH_LA,
      PSQ_OP_CALL_LA, PSQ_OP_TABLE, PSQ_OP_RETURN, PSQ_OP_RETURN_SKIP, PSQ_OP_SKIP_IF,
      PSQ_OP_SET_PTR, PSQ_OP_SET_RAM_BIT, PSQ_OP_CLR_RAM_BIT, PSQ_OP_TEST_RAM_BIT,
      PSQ_OP_SET_PORT_BIT, PSQ_OP_CLR_PORT_BIT, PSQ_OP_TEST_PORT_BIT, PSQ_OP_SET_URS
   } psq_op_kind_t;

   // one decoded instruction handed to the sequencer
   typedef struct packed {
      psq_op_kind_t kind;
      logic [10:0] target;
      logic [3:0] page;
      logic [1:0] len;
      logic [1:0] file;
      logic [3:0] digit;
      logic [1:0] bit_sel;
      logic cond;
   } psq_op_t;
endpackage

//--- design/psq_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
`include "psq_defines.svh"
module psq_sequencer #(
   parameter int PC_W = 11,
   parameter int RAM_AW = 6
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic backup_return,
   input wire logic op_valid,
   input wire psq_pkg::psq_op_t op,
   input wire logic [3:0] accum,
   input wire logic [2:0] page_ptr,
   input wire logic [7:0] port_d_pin,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   output logic op_ready,
   output logic [PC_W-1:0] pc,
   output logic [1:0] stack_index,
   output logic skip_flag,
   output logic [8:0] instr_word,
   output logic [7:0] table_data,
   output logic carry_load,
   output logic carry_value,
   output logic [3:0] ram_rdata,
   output logic [7:0] port_d_out,
   output logic [7:0] port_d_oe_n
);
   import psq_pkg::*;

   logic [8:0] rom [2**PC_W];
   logic [3:0] ram [2**RAM_AW];
   logic [PC_W-1:0] stk_r [4];

   logic [PC_W-1:0] pc_r, pc_nxt, rom_addr_r;
   logic [1:0] stack_index_r, sp_nxt, wait_r, wait_nxt;
   logic skip_r, skip_nxt, pop_pend_r, pop_nxt, push, urs_r, hold_r, op_ready_r;
   logic [1:0] file_r;
   logic [3:0] digit_r;
   logic [7:0] pin_s1, pin_s2, pin_s3, pin_q, port_latch_r;
   logic [31:0] hrdata_r;
   logic wr_pend_r;
   logic [7:0] wr_addr_r;

   wire take = op_valid & op_ready_r;
   wire skipping = take & skip_r;
   wire exec = take & ~skip_r;
   // page and offset carry as one counter
   wire [PC_W-1:0] pc_seq = pc_r + PC_W'(op.len);
   // in-page address from page pointer and accumulator
   wire [PC_W-1:0] la_addr = {op.page, page_ptr, accum};
   wire [1:0] push_idx = stack_index_r + 2'h1;
   wire [PC_W-1:0] stk_top = stk_r[stack_index_r];
   // file and digit form the RAM address
   wire [RAM_AW-1:0] ram_addr = {file_r, digit_r};
   wire [3:0] ram_word = ram[ram_addr];
   // digit part selects the port D bit
   wire [2:0] port_sel = digit_r[2:0];
   wire port_bit = pin_q[port_sel];
   // any ROM word reachable as table data
   wire [8:0] tbl_word = rom[la_addr];
   wire is_table = exec && op.kind == PSQ_OP_TABLE;
   wire is_push = op.kind inside {PSQ_OP_CALL, PSQ_OP_PAGE2_CALL, PSQ_OP_CALL_LA, PSQ_OP_TABLE};
   wire ap_take = hsel & htrans[1] & hready;
   wire [7:0] ap_addr = haddr[7:0];
   wire wr_rom_addr = wr_pend_r && wr_addr_r == `PSQ_OFF_ROM_ADDR;
   wire wr_rom_data = wr_pend_r && wr_addr_r == `PSQ_OFF_ROM_DATA;
   wire wr_ctrl = wr_pend_r && wr_addr_r == `PSQ_OFF_CTRL;
   wire [15:0] status = {1'b0, urs_r, skip_r, stack_index_r, pc_r};
   wire [31:0] rd_mux = (ap_addr == `PSQ_OFF_ROM_ADDR) ? {21'h0, rom_addr_r} :
                        (ap_addr == `PSQ_OFF_ROM_DATA) ? {23'h0, rom[rom_addr_r]} :
                        (ap_addr == `PSQ_OFF_STATUS) ? {16'h0, status} :
                        (ap_addr == `PSQ_OFF_CTRL) ? {31'h0, hold_r} : 32'h0;
   wire hold_nxt = wr_ctrl ? hwdata[`PSQ_CTRL_HOLD_BIT] : hold_r;

   always_comb begin
      pc_nxt = pc_r;
      sp_nxt = stack_index_r;
      skip_nxt = skip_r;
      push = 1'b0;
      pop_nxt = pop_pend_r;
      wait_nxt = (wait_r != 2'h0) ? wait_r - 2'h1 : 2'h0;
      if (pop_pend_r && wait_r == 2'h1) begin
         // table lookup returns to the saved address
         pc_nxt = stk_top;
         sp_nxt = stack_index_r - 2'h1;
         pop_nxt = 1'b0;
      end
      if (skipping) begin
         // suppress instead of adding 2; flag consumed
         pc_nxt = op.len == 2'h0 ? pc_r : pc_seq;
         skip_nxt = 1'b0;
      end else if (exec) begin
         pc_nxt = pc_seq;
         unique case (op.kind)
            PSQ_OP_BRANCH: pc_nxt = op.target;
            PSQ_OP_BRANCH_LA: pc_nxt = la_addr;
            PSQ_OP_CALL: pc_nxt = op.target;
            PSQ_OP_PAGE2_CALL: pc_nxt = {`PSQ_PAGE2, op.target[6:0]};
            PSQ_OP_CALL_LA: pc_nxt = la_addr;
            PSQ_OP_TABLE: begin
               pop_nxt = 1'b1;
               wait_nxt = `PSQ_TBL_CYC - 2'h1;
            end
            PSQ_OP_RETURN, PSQ_OP_RETURN_SKIP: begin
               pc_nxt = stk_top;
               sp_nxt = stack_index_r - 2'h1;
               wait_nxt = `PSQ_RET_CYC - 2'h1;
               skip_nxt = op.kind == PSQ_OP_RETURN_SKIP;
            end
            // skip flag set on met condition
            PSQ_OP_SKIP_IF: skip_nxt = op.cond;
            PSQ_OP_TEST_RAM_BIT: skip_nxt = ~ram_word[op.bit_sel];
            PSQ_OP_TEST_PORT_BIT: skip_nxt = ~port_bit;
            default: pc_nxt = pc_seq;
         endcase
         if (is_push) begin
            // push wraps index 3 to 0
            push = 1'b1;
            sp_nxt = push_idx;
         end
      end
      if (backup_return) begin
         // back-up return restores the stack index
         sp_nxt = `PSQ_SP_RST;
         skip_nxt = 1'b0;
         pop_nxt = 1'b0;
         wait_nxt = 2'h0;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         pc_r <= `PSQ_PC_RST;
         stack_index_r <= `PSQ_SP_RST;
         skip_r <= 1'b0;
         wait_r <= 2'h0;
         pop_pend_r <= 1'b0;
         op_ready_r <= 1'b0;
      end else begin
         pc_r <= pc_nxt;
         stack_index_r <= sp_nxt;
         skip_r <= skip_nxt;
         wait_r <= wait_nxt;
         pop_pend_r <= pop_nxt;
         // skipped multi-cycle ops never start the wait count
         op_ready_r <= ~hold_nxt & (wait_nxt == 2'h0);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (push) begin
         stk_r[sp_nxt] <= pc_seq;
      end
      if (wr_rom_data) begin
         rom[rom_addr_r] <= hwdata[8:0];
      end
      // single-bit writes on any RAM word
      if (exec && op.kind == PSQ_OP_SET_RAM_BIT) begin
         ram[ram_addr][op.bit_sel] <= 1'b1;
      end
      if (exec && op.kind == PSQ_OP_CLR_RAM_BIT) begin
         ram[ram_addr][op.bit_sel] <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         urs_r <= 1'b0;
         carry_load <= 1'b0;
         carry_value <= 1'b0;
         table_data <= 8'h00;
         instr_word <= 9'h000;
         ram_rdata <= 4'h0;
         file_r <= 2'h0;
         digit_r <= 4'h0;
         port_latch_r <= 8'h00;
         port_d_oe_n <= 8'hFF;
      end else begin
         // msb flag only set by software, cleared by back-up return
         if (backup_return) begin
            urs_r <= 1'b0;
         end else if (exec && op.kind == PSQ_OP_SET_URS) begin
            urs_r <= 1'b1;
         end
         // bit 8 copied to carry when enabled
         carry_load <= is_table & urs_r;
         carry_value <= tbl_word[8];
         if (is_table) begin
            table_data <= tbl_word[7:0];
         end
         instr_word <= rom[pc_nxt];
         ram_rdata <= ram_word;
         if (exec && op.kind == PSQ_OP_SET_PTR) begin
            file_r <= op.file;
            digit_r <= op.digit;
         end
         // port bit set and clear at the digit position
         if (exec && op.kind == PSQ_OP_SET_PORT_BIT) begin
            port_latch_r[port_sel] <= 1'b1;
            port_d_oe_n[port_sel] <= 1'b0;
         end
         if (exec && op.kind == PSQ_OP_CLR_PORT_BIT) begin
            port_latch_r[port_sel] <= 1'b0;
            port_d_oe_n[port_sel] <= 1'b1;
         end
      end
   end

   // pin synchroniser: a change counts once the second and third stages agree
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         pin_s1 <= 8'h00;
         pin_s2 <= 8'h00;
         pin_s3 <= 8'h00;
         pin_q <= 8'h00;
      end else begin
         pin_s1 <= port_d_pin;
         pin_s2 <= pin_s1;
         pin_s3 <= pin_s2;
         pin_q <= (pin_s2 & pin_s3) | (pin_q & (pin_s2 ^ pin_s3));
      end
   end

   // bus slave: zero wait states, read data registered at the address phase
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         hrdata_r <= 32'h0;
         wr_pend_r <= 1'b0;
         wr_addr_r <= 8'h00;
         rom_addr_r <= '0;
         hold_r <= `PSQ_HOLD_RST;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         wr_pend_r <= ap_take & hwrite;
         wr_addr_r <= ap_addr;
         if (ap_take && !hwrite) begin
            hrdata_r <= rd_mux;
         end
         if (wr_rom_addr) begin
            rom_addr_r <= hwdata[PC_W-1:0];
         end else if (wr_rom_data) begin
            rom_addr_r <= rom_addr_r + PC_W'(1);
         end
         hold_r <= hold_nxt;
      end
   end

   assign hrdata = hrdata_r;
   assign op_ready = op_ready_r;
   assign pc = pc_r;
   assign stack_index = stack_index_r;
   assign skip_flag = skip_r;
   assign port_d_out = port_latch_r;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   chk_push_wrap: assert property (
      exec && is_push && stack_index_r == 2'h3 && !backup_return |=> stack_index_r == 2'h0)
      else $error("push at index 3 did not wrap to 0");
   chk_backup_index: assert property (
      backup_return |=> stack_index_r == 2'h3)
      else $error("back-up return did not set index 3");
   chk_page2_target: assert property (
      exec && op.kind == PSQ_OP_PAGE2_CALL && !backup_return |=> pc_r[10:7] == 4'h2)
      else $error("page-2 call left page 2");
   chk_saved_return: assert property (
      exec && is_push && !backup_return |=> stk_r[stack_index_r] == $past(pc_seq))
      else $error("pushed return address wrong");
   chk_skip_one_cycle: assert property (
      skipping && !wr_ctrl && !hold_r && !backup_return |=> !skip_r && op_ready_r)
      else $error("skipped instruction took more than one cycle");
   chk_page_carry: assert property (
      exec && op.kind == PSQ_OP_NEXT && op.len == 2'h1 && pc_r[6:0] == 7'h7F
      |=> pc_r[6:0] == 7'h00 && pc_r[10:7] == $past(pc_r[10:7]) + 4'h1)
      else $error("offset 127 did not carry into next page");
   chk_table_busy: assert property (
      is_table && !backup_return |=> !op_ready_r [*2])
      else $error("table lookup cycle count wrong");
   chk_carry_copy: assert property (
      is_table && urs_r |=> carry_load && carry_value == $past(tbl_word[8]))
      else $error("carry not loaded from word bit 8");
   chk_skip_set: assert property (
      exec && op.kind == PSQ_OP_SKIP_IF && op.cond && !backup_return |=> skip_r)
      else $error("skip flag not set");
   chk_port_select: assert property (
      exec && op.kind == PSQ_OP_SET_PORT_BIT |=> port_d_out[$past(port_sel)])
      else $error("port bit not set at digit position");

   cov_wrap: cover property (exec && is_push && stack_index_r == 2'h3);
   cov_skip_table: cover property (skipping && op.kind == PSQ_OP_TABLE);
   cov_ret_skip: cover property (exec && op.kind == PSQ_OP_RETURN_SKIP ##2 skipping);
endmodule // psq_sequencer
`default_nettype wire

//--- tb/psq_port_model.sv
`timescale 1ns/1ps
`default_nettype none
module psq_port_model (
   input wire logic [7:0] latch,
   input wire logic [7:0] oe_n,
   output logic [7:0] pin
);
   // open-drain high side only; the pull-down holds a released pin low
   assign pin = latch & ~oe_n;
endmodule // psq_port_model
`default_nettype wire

//--- tb/psq_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "psq_defines.svh"
module psq_sequencer_tb;
   import psq_pkg::*;
   logic ref_clk = 1'h0;
   logic reset_n = 1'h0;
   logic backup_return = 1'h0;
   logic op_valid = 1'h0;
   psq_op_t op = '0;
   logic [3:0] accum = 4'h0;
   logic [2:0] page_ptr = 3'h0;
   logic [7:0] port_d_pin;
   logic hsel = 1'h0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'h0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic [31:0] rd;
   logic hreadyout, hresp, op_ready, skip_flag, carry_load, carry_value;
   logic [10:0] pc;
   logic [1:0] stack_index;
   logic [7:0] table_data, port_d_out, port_d_oe_n;
   logic [3:0] ram_rdata;
   logic [8:0] instr_word;
   int err_count = 0;
   int check_count = 0;
   int cyc = 0;

   psq_sequencer i_psq_sequencer (
      .ref_clk, .reset_n, .backup_return, .op_valid, .op, .accum, .page_ptr,
      .port_d_pin, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hrdata, .hreadyout, .hresp, .op_ready, .pc,
      .stack_index, .skip_flag, .instr_word, .table_data, .carry_load,
      .carry_value, .ram_rdata, .port_d_out, .port_d_oe_n
   );
   psq_port_model i_psq_port_model (.latch(port_d_out), .oe_n(port_d_oe_n), .pin(port_d_pin));

   initial begin
      forever #10 ref_clk = ~ref_clk;
   end

   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 3000) begin
         err_count++;
         end_sim();
      end
   end

   task end_sim();
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         err_count++;
         $display("[FAIL] %0t got %h expected %h", $time, g, e);
      end
   endtask

   task ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
      @(posedge ref_clk);
      hsel <= 1'h1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      do begin
         @(posedge ref_clk);
      end while (hreadyout !== 1'h1);
      htrans <= 2'h0;
      hsel <= 1'h0;
      hwdata <= wd;
      do begin
         @(posedge ref_clk);
      end while (hreadyout !== 1'h1);
      rd = hrdata;
   endtask

   // offers one op and holds it until the edge that takes it
   task do_op(input psq_op_kind_t k, input logic [10:0] t = 11'h0,
              input logic c = 1'h0, input logic [1:0] l = 2'h1);
      @(posedge ref_clk);
      op <= '{kind:k, target:t, page:t[10:7], len:l, file:2'h2, digit:4'h5,
              bit_sel:t[1:0], cond:c};
      op_valid <= 1'h1;
      do begin
         @(posedge ref_clk);
      end while (op_ready !== 1'h1);
      op_valid <= 1'h0;
      #1;
   endtask

   task settle();
      repeat (3) @(posedge ref_clk);
      #1;
   endtask

   task t_reset();
      chk(pc, 11'h0);
      chk(stack_index, 2'h3);
      chk(skip_flag, 1'h0);
      chk(hreadyout, 1'h1);
      chk(hresp, 1'h0);
   endtask

   task t_bus();
      ahb(1'h1, `PSQ_OFF_CTRL, 32'h0);
      ahb(1'h0, `PSQ_OFF_STATUS, 32'h0);
      chk(rd[12:11], 2'h3);
      chk(rd[14], 1'h0);
      ahb(1'h0, 32'h40, 32'h0);
      chk(rd, 32'h0);
      ahb(1'h1, `PSQ_OFF_ROM_ADDR, 32'h1C3);
      ahb(1'h1, `PSQ_OFF_ROM_DATA, 32'h1A5);
      ahb(1'h1, `PSQ_OFF_ROM_ADDR, 32'h1C3);
      ahb(1'h0, `PSQ_OFF_ROM_DATA, 32'h0);
      chk(rd[8:0], 9'h1A5);
   endtask

   task t_stack();
      do_op(PSQ_OP_PAGE2_CALL, 11'h105);
      chk(stack_index, 2'h0);
      chk(pc, 11'h105);
      do_op(PSQ_OP_CALL, 11'h200);
      do_op(PSQ_OP_CALL, 11'h300);
      do_op(PSQ_OP_CALL, 11'h400);
      chk(stack_index, 2'h3);
      do_op(PSQ_OP_CALL, 11'h500);
      chk(stack_index, 2'h0);
      do_op(PSQ_OP_RETURN);
      settle();
      chk(pc, 11'h401);
      chk(stack_index, 2'h3);
      do_op(PSQ_OP_RETURN);
      settle();
      chk(pc, 11'h301);
   endtask

   task t_pc();
      do_op(PSQ_OP_BRANCH, 11'h07F);
      chk(pc, 11'h07F);
      do_op(PSQ_OP_NEXT);
      chk(pc, 11'h080);
      do_op(PSQ_OP_NEXT, 11'h0, 1'h0, 2'h2);
      chk(pc, 11'h082);
   endtask

   task t_skip();
      do_op(PSQ_OP_SKIP_IF, 11'h0, 1'h1);
      chk(skip_flag, 1'h1);
      do_op(PSQ_OP_RETURN);
      chk(op_ready, 1'h1);
      chk(stack_index, 2'h2);
      chk(skip_flag, 1'h0);
      chk(pc, 11'h084);
      do_op(PSQ_OP_SKIP_IF);
      chk(skip_flag, 1'h0);
   endtask

   task t_table();
      int n;
      accum <= 4'h3;
      page_ptr <= 3'h4;
      do_op(PSQ_OP_SET_URS);
      do_op(PSQ_OP_TABLE, 11'h180);
      chk(stack_index, 2'h3);
      n = 0;
      repeat (4) begin
         if (carry_load === 1'h1) n++;
         @(posedge ref_clk);
         #1;
      end
      chk(n, 1);
      chk(carry_value, 1'h1);
      chk(table_data, 8'hA5);
      chk(stack_index, 2'h2);
      chk(pc, 11'h087);
      ahb(1'h0, `PSQ_OFF_STATUS, 32'h0);
      chk(rd[14], 1'h1);
   endtask

   task t_ram();
      do_op(PSQ_OP_SET_PTR);
      do_op(PSQ_OP_SET_RAM_BIT, 11'h2);
      settle();
      chk(ram_rdata[2], 1'h1);
      do_op(PSQ_OP_TEST_RAM_BIT, 11'h2);
      chk(skip_flag, 1'h0);
      do_op(PSQ_OP_CLR_RAM_BIT, 11'h2);
      do_op(PSQ_OP_TEST_RAM_BIT, 11'h2);
      chk(skip_flag, 1'h1);
      do_op(PSQ_OP_NEXT);
      do_op(PSQ_OP_SET_PORT_BIT);
      chk(port_d_out[5], 1'h1);
      chk(port_d_oe_n[5], 1'h0);
      settle();
      do_op(PSQ_OP_TEST_PORT_BIT);
      chk(skip_flag, 1'h0);
   endtask

   task t_backup();
      @(posedge ref_clk);
      backup_return <= 1'h1;
      @(posedge ref_clk);
      backup_return <= 1'h0;
      #1;
      chk(stack_index, 2'h3);
      ahb(1'h0, `PSQ_OFF_STATUS, 32'h0);
      chk(rd[14], 1'h0);
   endtask

   task t_more();
      // every target stays inside the sixteen pages
      do_op(PSQ_OP_BRANCH_LA, 11'h100);
      chk(pc, 11'h143);
      do_op(PSQ_OP_CALL_LA, 11'h080);
      chk(pc, 11'h0C3);
      chk(stack_index, 2'h0);
      do_op(PSQ_OP_RETURN_SKIP);
      chk(pc, 11'h144);
      chk(skip_flag, 1'h1);
      do_op(PSQ_OP_TABLE, 11'h180);
      chk(op_ready, 1'h1);
      chk(stack_index, 2'h3);
      chk(pc, 11'h145);
      chk(skip_flag, 1'h0);
      do_op(PSQ_OP_CLR_PORT_BIT);
      chk(port_d_out[5], 1'h0);
      chk(port_d_oe_n[5], 1'h1);
      do_op(PSQ_OP_BRANCH, 11'h1C3);
      chk(instr_word, 9'h1A5);
   endtask

   initial begin
      repeat (16) @(posedge ref_clk);
      reset_n <= 1'h1;
      #1;
      t_reset();
      t_bus();
      t_stack();
      t_pc();
      t_skip();
      t_table();
      t_ram();
      t_backup();
      t_more();
      end_sim();
   end
endmodule // psq_sequencer_tb
`default_nettype wire
